// ### bench/msc_host_model.sv
// Host controller model: 2-wire master and pull-ups of the shared lines
`timescale 1ns/10ps
`default_nettype none
module msc_host_model
(
  input wire logic clock_in, // Bench clock
  input wire logic dev_sda_in, // Device data value
  input wire logic dev_sda_oe_in, // Device data enable
  input wire logic dev_int_in, // Device interrupt value
  input wire logic dev_int_oe_in, // Device interrupt enable
  input wire logic dev_present_in, // Device presence tie
  output logic scl_out, // Serial clock, idle high
  output logic sda_wire_out, // Resolved data line
  output logic int_wire_out, // Resolved interrupt line
  output logic present_wire_out // Resolved presence line
);
  logic sda_low_reg = 1'b0; // Host pulls data low
  initial scl_out = 1'b1;
  // Data line with pull-up, low if either side pulls
  assign sda_wire_out = ~(sda_low_reg | (dev_sda_oe_in & ~dev_sda_in));
  // Host pull-up on the interrupt line
  assign int_wire_out = ~(dev_int_oe_in & ~dev_int_in);
  // Host pull-up, grounded by the inserted module
  assign present_wire_out = dev_present_in;
  // Wait a number of clock edges
  task automatic tick(input int n);
    repeat (n) @(posedge clock_in);
  endtask
  // Start or repeated start; leaves the clock low
  task automatic start_cond();
    sda_low_reg <= 1'b0;
    tick(1);
    scl_out <= 1'b1;
    tick(3);
    sda_low_reg <= 1'b1;
    tick(3);
    scl_out <= 1'b0;
    tick(1);
  endtask
  // Stop condition; clock and data left high
  task automatic stop_cond();
    sda_low_reg <= 1'b1;
    tick(3);
    scl_out <= 1'b1;
    tick(3);
    sda_low_reg <= 1'b0;
    tick(2);
  endtask
  // Eight bits MSB first, then a released ninth bit; nak set when nobody pulled
  task automatic xfer(input logic [7:0] d, output logic [7:0] q, output logic nak);
    logic b;
    for (int i = 7; i >= -1; i--)
    begin
      b = (i >= 0) ? d[i] : 1'b1;
      sda_low_reg <= ~b;
      tick(3);
      scl_out <= 1'b1;
      tick(3);
      if (i >= 0)
        q[i] = sda_wire_out;
      else
        nak = sda_wire_out;
      tick(1);
      scl_out <= 1'b0;
      tick(1);
    end
  endtask
endmodule
`default_nettype wire

// ### bench/msc_sideband_chk.sv
// Port checker of the sideband control block
`timescale 1ns/10ps
`default_nettype none
module msc_sideband_chk
#(
  parameter int RESET_MIN = 4 // Minimum reset pulse in cycles
)
(
  input wire logic clock_in, // Module clock
  input wire logic sys_rst_in, // Synchronous reset
  input wire logic module_select_n_in, // Select pin
  input wire logic module_reset_n_in, // Reset pin
  input wire logic init_control_select_in, // Init mode level
  input wire logic init_control_driven_in, // Init mode driven
  input wire logic fault_in, // Core fault
  input wire logic sda_oe_out, // Data pull-down
  input wire logic interrupt_n_out, // Interrupt value
  input wire logic interrupt_n_oe_out, // Interrupt pull-down
  input wire logic module_present_n_out, // Presence level
  input wire logic low_power_select_out, // Low power mode
  input wire logic data_not_ready_out // Not-ready flag
);
  logic [15:0] low_cnt_reg; // Cycles the reset pin stayed low
  logic [15:0] low_cnt_next;
  // Saturating count of reset pin low time
  always_comb
  begin
    low_cnt_next = low_cnt_reg;
    if (module_reset_n_in)
      low_cnt_next = 16'h0000;
    else if (low_cnt_reg != 16'hFFFF)
      low_cnt_next = low_cnt_reg + 16'h0001;
  end
  // Register the count
  always_ff @(posedge clock_in)
  begin
    low_cnt_reg <= low_cnt_next;
  end
  default clocking cb @(posedge clock_in); endclocking
  default disable iff (sys_rst_in);
  a_present_tied: assert property (module_present_n_out == 1'b0)
    else $error("presence line not low");
  a_int_pull_down: assert property (interrupt_n_out == 1'b0)
    else $error("interrupt drives high");
  a_reset_values: assert property ($fell(sys_rst_in) |->
    low_power_select_out && data_not_ready_out && !interrupt_n_oe_out)
    else $error("reset values wrong");
  a_ready_posts_int: assert property ($fell(data_not_ready_out) |->
    ##[0:1] interrupt_n_oe_out)
    else $error("no interrupt at completion");
  a_low_power_early: assert property (data_not_ready_out |-> low_power_select_out)
    else $error("high power before ready");
  a_deselect_quiet: assert property (module_select_n_in [*8] |-> !sda_oe_out)
    else $error("bus answered while deselected");
  a_long_reset: assert property (low_cnt_reg >= RESET_MIN + 6 |-> data_not_ready_out)
    else $error("long reset pulse not taken");
  a_hw_init_mode: assert property ($fell(data_not_ready_out) && init_control_driven_in
    && !init_control_select_in |-> ##[0:2] !low_power_select_out)
    else $error("hardware mode stayed in low power");
  a_fault_raises: assert property (fault_in && !data_not_ready_out |->
    ##[1:4] interrupt_n_oe_out)
    else $error("fault gave no interrupt");
  c_ready: cover property ($fell(data_not_ready_out));
  c_fault: cover property (fault_in ##[1:4] interrupt_n_oe_out);
  c_long_reset: cover property (!module_reset_n_in [*8]);
endmodule
bind msc_sideband msc_sideband_chk #(.RESET_MIN(RESET_MIN)) u_chk (
  .clock_in(clock_in), .sys_rst_in(sys_rst_in), .module_select_n_in(module_select_n_in),
  .module_reset_n_in(module_reset_n_in), .init_control_select_in(init_control_select_in),
  .init_control_driven_in(init_control_driven_in), .fault_in(fault_in),
  .sda_oe_out(sda_oe_out), .interrupt_n_out(interrupt_n_out),
  .interrupt_n_oe_out(interrupt_n_oe_out), .module_present_n_out(module_present_n_out),
  .low_power_select_out(low_power_select_out), .data_not_ready_out(data_not_ready_out));
`default_nettype wire

// ### bench/msc_sideband_test.sv
// Self-checking bench of the sideband control block
`timescale 1ns/10ps
`default_nettype none
module msc_sideband_test;
  logic clock_in = 1'b0; // Module clock
  logic sys_rst_in = 1'b1; // Power-up reset
  logic sel_n = 1'b0; // Dedicated select line of this module
  logic rst_n = 1'b1; // Reset pin
  logic init_lvl = 1'b0; // Level when host drives init mode
  logic init_drv = 1'b0; // Host drives init mode
  logic fault = 1'b0; // Core fault
  logic scl, sda, sda_v, sda_oe, int_v, int_oe, prs, lp, nrdy, int_w, prs_w;
  logic [7:0] d; // Read data
  logic nak; // Write refused
  int n_fail = 0;
  int n_checks = 0;
  always #20 clock_in = ~clock_in;
  msc_sideband #(.RESET_MIN(4), .INIT_CYC(4)) dut (.clock_in(clock_in),
    .sys_rst_in(sys_rst_in), .module_select_n_in(sel_n), .module_reset_n_in(rst_n),
    .init_control_select_in(init_drv ? init_lvl : 1'b1),
    .init_control_driven_in(init_drv), .scl_in(scl), .sda_in(sda), .sda_out(sda_v),
    .sda_oe_out(sda_oe), .fault_in(fault), .interrupt_n_out(int_v),
    .interrupt_n_oe_out(int_oe), .module_present_n_out(prs),
    .low_power_select_out(lp), .data_not_ready_out(nrdy));
  msc_host_model host (.clock_in(clock_in), .dev_sda_in(sda_v), .dev_sda_oe_in(sda_oe),
    .dev_int_in(int_v), .dev_int_oe_in(int_oe), .dev_present_in(prs), .scl_out(scl),
    .sda_wire_out(sda), .int_wire_out(int_w), .present_wire_out(prs_w));
  // Compare one value
  task automatic check(input string what, input logic [7:0] seen, input logic [7:0] exp);
    n_checks++;
    if (seen !== exp)
    begin
      $display("MISMATCH %s expected %h seen %h", what, exp, seen);
      n_fail++;
    end
  endtask
  // Pointer then one data byte
  task automatic reg_wr(input logic [7:0] ptr, input logic [7:0] v, output logic n);
    logic [7:0] q;
    logic n0, n1, n2;
    host.start_cond();
    host.xfer({msc_pkg::DEV_ADDR, 1'b0}, q, n0);
    host.xfer(ptr, q, n1);
    host.xfer(v, q, n2);
    host.stop_cond();
    n = n0 | n1 | n2;
  endtask
  // Pointer, repeated start, one byte closed by a master NAK
  task automatic reg_rd(input logic [7:0] ptr, output logic [7:0] v);
    logic n;
    host.start_cond();
    host.xfer({msc_pkg::DEV_ADDR, 1'b0}, v, n);
    host.xfer(ptr, v, n);
    host.start_cond();
    host.xfer({msc_pkg::DEV_ADDR, 1'b1}, v, n);
    host.xfer(8'hFF, v, n);
    host.stop_cond();
  endtask
  // Status is ignored until completion shows, bounded wait
  task automatic wait_ready();
    for (int k = 0; k < 400 && nrdy !== 1'b0; k++)
      @(posedge clock_in);
    repeat (3) @(posedge clock_in);
  endtask
  // Totals and verdict
  task automatic final_report();
    $display("checks %0d mismatches %0d", n_checks, n_fail);
    if (n_fail == 0 && n_checks > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask
  initial
  begin
    repeat (2) @(posedge clock_in);
    sys_rst_in <= 1'b0;
    wait_ready();
    check("int line", int_w, 0);
    check("low power", lp, 1);
    check("presence", prs_w, 0);
    reg_rd(msc_pkg::STATUS_OFFSET, d);
    check("not ready", d[0], 0);
    reg_rd(msc_pkg::INT_SRC_OFFSET, d);
    check("source", d, 8'h01);
    check("int released", int_w, 1);
    reg_wr(msc_pkg::CONTROL_OFFSET, 8'h01, nak);
    check("write ack", nak, 0);
    check("high power", lp, 0);
    $display("done: power-up and software mode");
    sel_n <= 1'b1;
    reg_wr(msc_pkg::CONTROL_OFFSET, 8'h00, nak);
    check("deselect ack", nak, 1);
    check("deselect map", lp, 0);
    sel_n <= 1'b0;
    fault <= 1'b1;
    @(posedge clock_in);
    fault <= 1'b0;
    repeat (4) @(posedge clock_in);
    check("fault int", int_w, 0);
    reg_rd(msc_pkg::INT_SRC_OFFSET, d);
    check("fault source", d, 8'h02);
    $display("done: select and fault");
    rst_n <= 1'b0;
    repeat (2) @(posedge clock_in);
    rst_n <= 1'b1;
    repeat (8) @(posedge clock_in);
    check("short pulse", nrdy, 0);
    rst_n <= 1'b0;
    repeat (12) @(posedge clock_in);
    check("long pulse", nrdy, 1);
    rst_n <= 1'b1;
    wait_ready();
    reg_rd(msc_pkg::CONTROL_OFFSET, d);
    check("control default", d, msc_pkg::CONTROL_RESET);
    check("default power", lp, 1);
    $display("done: reset pin");
    sys_rst_in <= 1'b1;
    init_drv <= 1'b1;
    init_lvl <= 1'b0;
    repeat (2) @(posedge clock_in);
    sys_rst_in <= 1'b0;
    wait_ready();
    check("hardware mode", lp, 0);
    $display("done: hardware init mode");
    final_report();
  end
  // Watchdog against a hung handshake
  initial
  begin
    repeat (20000) @(posedge clock_in);
    n_fail++;
    final_report();
  end
endmodule
`default_nettype wire

// ### include/msc_pkg.sv
// Package of constants for the module sideband control block
package msc_pkg;
  // Internal clock period in nanoseconds
  localparam int CLK_PERIOD_NS = 40;
  // Default minimum reset pulse length in nanoseconds
  localparam int RESET_MIN_NS = 2000;
  // Reset pulse length in cycles, rounded up
  localparam int RESET_MIN_CYC = (RESET_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  // Settling time of the management interface after reset, in nanoseconds
  localparam int MGMT_INIT_NS = 4000;
  // Settling time in cycles, rounded up
  localparam int MGMT_INIT_CYC = (MGMT_INIT_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  // Width of the pulse counters
  localparam int CNT_W = 16;
  // Device address of the management port on the 2-wire bus
  localparam logic [6:0] DEV_ADDR = 7'h50;
  // Offset of the status byte that holds the not-ready flag
  localparam logic [7:0] STATUS_OFFSET = 8'h02;
  // Bit position of the not-ready flag in the status byte
  localparam int NOT_READY_BIT = 0;
  // Offset of the control byte that holds the high power enable
  localparam logic [7:0] CONTROL_OFFSET = 8'h1A;
  // Bit position of the software high power enable
  localparam int HP_ENABLE_BIT = 0;
  // Offset of the interrupt source byte
  localparam logic [7:0] INT_SRC_OFFSET = 8'h03;
  // Reset values of the control bits and the flags
  localparam logic [7:0] CONTROL_RESET = 8'h00;
  localparam logic [7:0] STATUS_RESET = 8'h01;
  // Sequencer states
  typedef enum logic [1:0] {
    MSC_RESET = 2'b00,
    MSC_INIT = 2'b01,
    MSC_READY = 2'b10
  } msc_state_t;
endpackage

// ### rtl/msc_sideband.sv
// Sideband control of a pluggable cable end module: select, reset, init mode, interrupt
`timescale 1ns/10ps
`default_nettype none
// Function
// R1: Serial commands acted on only while selected
// R2: Host drives one select line per module
// R3: Memory map reached through serial clock, data
// R4: Long reset low restores all defaults
// R5: Host ignores status until reset completes
// R6: Completion asserts interrupt, clears not-ready flag
// R7: Completion interrupt posted after power-up too
// R8: Init-mode input pulled up internally
// R9: Init high: low power until software enables
// R10: Init low: high power after interface ready
// R11: Host keeps init-mode level while present
// R12: Presence line tied to ground
// R13: Interrupt driven low on fault or status
// R14: Host reads source over serial interface
// R15: Interrupt is open-collector pull-down only
// R16: Inputs synchronised, reset low time counted
module msc_sideband
#(
  parameter int RESET_MIN = msc_pkg::RESET_MIN_CYC, // Minimum reset pulse in cycles
  parameter int INIT_CYC = msc_pkg::MGMT_INIT_CYC // Interface settling in cycles
)
(
  input wire logic clock_in, // Module clock, 25 MHz
  input wire logic sys_rst_in, // Synchronous power-on reset
  input wire logic module_select_n_in, // Select pin, low selects
  input wire logic module_reset_n_in, // Reset pin, low resets
  input wire logic init_control_select_in, // Init mode pin level
  input wire logic init_control_driven_in, // High while host drives init mode
  input wire logic scl_in, // Serial clock pin
  input wire logic sda_in, // Serial data pin level
  output logic sda_out, // Serial data drive value
  output logic sda_oe_out, // Serial data drive enable
  input wire logic fault_in, // Operational fault from the core
  output logic interrupt_n_out, // Interrupt drive value, always low
  output logic interrupt_n_oe_out, // Interrupt pull-down enable
  output logic module_present_n_out, // Presence line level, tied low
  output logic low_power_select_out, // High while in low power mode
  output logic data_not_ready_out // Not-ready flag as held in the map
);
  // Synchroniser stages
  logic [1:0] sel_sync_reg, rst_sync_reg, init_sync_reg, scl_sync_reg, sda_sync_reg;
  logic init_raw; // Pin level with internal pull-up
  logic sel_n, rst_n, init_lvl; // Synchronised levels
  logic [msc_pkg::CNT_W-1:0] rcnt_reg, rcnt_next; // Reset low counter
  logic [msc_pkg::CNT_W-1:0] icnt_reg, icnt_next; // Settling counter
  msc_pkg::msc_state_t st_reg, st_next; // Sequencer
  logic [7:0] ctrl_reg, ctrl_next; // Control byte
  logic nr_reg, nr_next; // Not-ready flag
  logic done_reg, done_next; // Sticky reset-complete source
  logic flt_reg, flt_next; // Sticky fault source
  logic int_reg, int_next; // Interrupt pull-down
  logic lp_reg, lp_next; // Low power mode
  logic soft_rst; // Full reset request
  logic [7:0] wa, wd, ra, rdat; // Map access
  logic ws, rs, twi_oe;

  // Undriven init pin reads high [R8]
  assign init_raw = init_control_driven_in ? init_control_select_in : 1'b1;

  // Two-stage synchronisers on every pin input [R16]
  always_ff @(posedge clock_in)
  begin
    if (sys_rst_in)
    begin
      sel_sync_reg <= 2'b11;
      rst_sync_reg <= 2'b11;
      init_sync_reg <= 2'b11;
      scl_sync_reg <= 2'b11;
      sda_sync_reg <= 2'b11;
    end
    else
    begin
      sel_sync_reg <= {sel_sync_reg[0], module_select_n_in};
      rst_sync_reg <= {rst_sync_reg[0], module_reset_n_in};
      init_sync_reg <= {init_sync_reg[0], init_raw};
      scl_sync_reg <= {scl_sync_reg[0], scl_in};
      sda_sync_reg <= {sda_sync_reg[0], sda_in};
    end
  end

  assign sel_n = sel_sync_reg[1];
  assign rst_n = rst_sync_reg[1];
  assign init_lvl = init_sync_reg[1];
  // Reset counted long enough triggers a complete reset [R4]
  assign soft_rst = !rst_n && (rcnt_reg >= msc_pkg::CNT_W'(RESET_MIN));

  // Serial slave for the management map, live only while selected [R1] [R3]
  msc_twi_slave u_twi
  (
    .clock_in(clock_in),
    .sys_rst_in(sys_rst_in | soft_rst),
    .enable_in(~sel_n),
    .scl_in(scl_sync_reg[1]),
    .sda_in(sda_sync_reg[1]),
    .sda_oe_out(twi_oe),
    .wr_addr_out(wa),
    .wr_data_out(wd),
    .wr_strobe_out(ws),
    .rd_addr_out(ra),
    .rd_data_in(rdat),
    .rd_strobe_out(rs)
  );

  // Read mux of the map: status, interrupt sources, control
  always_comb
  begin
    rdat = 8'h00;
    if (ra == msc_pkg::STATUS_OFFSET)
    begin
      rdat[msc_pkg::NOT_READY_BIT] = nr_reg;
    end
    else if (ra == msc_pkg::INT_SRC_OFFSET)
    begin
      rdat = {6'h00, flt_reg, done_reg};
    end
    else if (ra == msc_pkg::CONTROL_OFFSET)
    begin
      rdat = ctrl_reg;
    end
  end

  // Next values of the sequencer, flags and power mode
  always_comb
  begin
    st_next = st_reg;
    rcnt_next = rcnt_reg;
    icnt_next = icnt_reg;
    ctrl_next = ctrl_reg;
    nr_next = nr_reg;
    done_next = done_reg;
    flt_next = flt_reg | fault_in;
    lp_next = lp_reg;
    // Count reset low time, saturating [R16]
    if (rst_n)
    begin
      rcnt_next = '0;
    end
    else if (rcnt_reg != '1)
    begin
      rcnt_next = rcnt_reg + msc_pkg::CNT_W'(1);
    end
    // Software writes to the control byte
    if (ws && wa == msc_pkg::CONTROL_OFFSET)
    begin
      ctrl_next = wd;
    end
    // Reading the source byte clears it; a new event wins [R14]
    if (rs && ra == msc_pkg::INT_SRC_OFFSET)
    begin
      done_next = 1'b0;
      flt_next = fault_in;
    end
    case (st_reg)
      msc_pkg::MSC_RESET:
      begin
        // Hold here while the reset pin stays low
        nr_next = 1'b1;
        lp_next = 1'b1;
        icnt_next = '0;
        if (rst_n)
        begin
          st_next = msc_pkg::MSC_INIT;
        end
      end
      msc_pkg::MSC_INIT:
      begin
        icnt_next = icnt_reg + msc_pkg::CNT_W'(1);
        if (icnt_reg >= msc_pkg::CNT_W'(INIT_CYC))
        begin
          // Completion: clear not-ready, post interrupt [R6] [R7]
          nr_next = 1'b0;
          done_next = 1'b1;
          st_next = msc_pkg::MSC_READY;
        end
      end
      msc_pkg::MSC_READY:
      begin
        // Init low: hardware control goes high power [R10]
        // Init high: wait for software enable [R9]
        lp_next = init_lvl ? ~ctrl_reg[msc_pkg::HP_ENABLE_BIT] : 1'b0;
      end
      default:
      begin
        st_next = msc_pkg::MSC_RESET;
      end
    endcase
    // Complete reset restores every default [R4]
    if (soft_rst)
    begin
      st_next = msc_pkg::MSC_RESET;
      ctrl_next = msc_pkg::CONTROL_RESET;
      nr_next = 1'b1;
      done_next = 1'b0;
      flt_next = 1'b0;
      lp_next = 1'b1;
    end
    // Pull interrupt low while any source is pending [R13]
    int_next = done_next | flt_next;
  end

  // Registers of the sequencer; power-up enters reset sequence [R7]
  always_ff @(posedge clock_in)
  begin
    if (sys_rst_in)
    begin
      st_reg <= msc_pkg::MSC_RESET;
      rcnt_reg <= '0;
      icnt_reg <= '0;
      ctrl_reg <= msc_pkg::CONTROL_RESET;
      nr_reg <= msc_pkg::STATUS_RESET[msc_pkg::NOT_READY_BIT];
      done_reg <= 1'b0;
      flt_reg <= 1'b0;
      int_reg <= 1'b0;
      lp_reg <= 1'b1;
    end
    else
    begin
      st_reg <= st_next;
      rcnt_reg <= rcnt_next;
      icnt_reg <= icnt_next;
      ctrl_reg <= ctrl_next;
      nr_reg <= nr_next;
      done_reg <= done_next;
      flt_reg <= flt_next;
      int_reg <= int_next;
      lp_reg <= lp_next;
    end
  end

  // Open-collector outputs: value low, enable pulls down [R15]
  assign interrupt_n_out = 1'b0;
  assign interrupt_n_oe_out = int_reg;
  assign sda_out = 1'b0;
  assign sda_oe_out = twi_oe;
  // Presence line tied to ground [R12]
  assign module_present_n_out = 1'b0;
  assign low_power_select_out = lp_reg;
  assign data_not_ready_out = nr_reg;
endmodule
`default_nettype wire

// ### rtl/msc_twi_slave.sv
// Byte-wide 2-wire serial slave that reads and writes the management map
`timescale 1ns/10ps
`default_nettype none
module msc_twi_slave
(
  input wire logic clock_in, // Module clock
  input wire logic sys_rst_in, // Synchronous reset, active high
  input wire logic enable_in, // Select held low, bus is live
  input wire logic scl_in, // Synchronised serial clock
  input wire logic sda_in, // Synchronised serial data
  output logic sda_oe_out, // Pull data low while high
  output logic [7:0] wr_addr_out, // Address of a write
  output logic [7:0] wr_data_out, // Data of a write
  output logic wr_strobe_out, // One-cycle write pulse
  output logic [7:0] rd_addr_out, // Address being read
  input wire logic [7:0] rd_data_in, // Data at rd_addr_out
  output logic rd_strobe_out // One-cycle pulse after a byte is read
);
  // Bus phases
  typedef enum logic [2:0] {
    TW_IDLE = 3'b000,
    TW_DEV = 3'b001,
    TW_ACK = 3'b010,
    TW_WDATA = 3'b011,
    TW_RDATA = 3'b100,
    TW_RACK = 3'b101
  } msc_twi_t;

  msc_twi_t st_reg, st_next; // Phase
  logic scl_reg, sda_reg; // Previous line levels
  logic [7:0] sh_reg, sh_next; // Shift register
  logic [3:0] bit_reg, bit_next; // Bit counter
  logic [7:0] ptr_reg, ptr_next; // Map pointer
  logic have_ptr_reg, have_ptr_next; // Pointer byte received
  logic rd_reg, rd_next; // Read transfer
  logic oe_reg, oe_next; // Data pull-down
  logic wr_reg, wr_next; // Write pulse
  logic [7:0] wd_reg, wd_next; // Write data
  logic rs_reg, rs_next; // Read pulse
  logic rise, fall, start, stop; // Line events

  // Edge and condition detection on the synchronised lines
  always_comb
  begin
    rise = scl_in & ~scl_reg;
    fall = ~scl_in & scl_reg;
    start = scl_in & scl_reg & sda_reg & ~sda_in;
    stop = scl_in & scl_reg & ~sda_reg & sda_in;
  end

  // Next-state logic of the slave
  always_comb
  begin
    st_next = st_reg;
    sh_next = sh_reg;
    bit_next = bit_reg;
    ptr_next = ptr_reg;
    have_ptr_next = have_ptr_reg;
    rd_next = rd_reg;
    oe_next = oe_reg;
    wr_next = 1'b0;
    wd_next = wd_reg;
    rs_next = 1'b0;
    // Advance the pointer one cycle after the read pulse, so the map still sees the byte read
    if (rs_reg)
    begin
      ptr_next = ptr_reg + 8'h01;
    end
    if (!enable_in || stop)
    begin
      // Deselected or stopped: release the line [R1]
      st_next = TW_IDLE;
      oe_next = 1'b0;
    end
    else if (start)
    begin
      st_next = TW_DEV;
      bit_next = 4'h0;
      oe_next = 1'b0;
      have_ptr_next = 1'b0;
    end
    else
    begin
      case (st_reg)
        TW_IDLE:
        begin
          oe_next = 1'b0;
        end
        TW_DEV, TW_WDATA:
        begin
          if (rise)
          begin
            sh_next = {sh_reg[6:0], sda_in};
            bit_next = bit_reg + 4'h1;
          end
          if (fall && bit_reg == 4'h8)
          begin
            bit_next = 4'h0;
            if (st_reg == TW_DEV)
            begin
              // Acknowledge only our own address
              if (sh_reg[7:1] == msc_pkg::DEV_ADDR)
              begin
                oe_next = 1'b1;
                rd_next = sh_reg[0];
                st_next = TW_ACK;
              end
              else
              begin
                st_next = TW_IDLE;
              end
            end
            else
            begin
              oe_next = 1'b1;
              st_next = TW_ACK;
              if (!have_ptr_reg)
              begin
                ptr_next = sh_reg;
                have_ptr_next = 1'b1;
              end
              else
              begin
                // Write into the map, pointer then advances [R3]
                wr_next = 1'b1;
                wd_next = sh_reg;
                ptr_next = ptr_reg + 8'h01;
              end
            end
          end
        end
        TW_ACK:
        begin
          if (fall)
          begin
            if (rd_reg)
            begin
              // Drive first data bit, low bits pull down
              oe_next = ~rd_data_in[7];
              sh_next = {rd_data_in[6:0], 1'b0};
              bit_next = 4'h1;
              st_next = TW_RDATA;
            end
            else
            begin
              oe_next = 1'b0;
              st_next = TW_WDATA;
            end
          end
        end
        TW_RDATA:
        begin
          if (fall)
          begin
            if (bit_reg == 4'h8)
            begin
              oe_next = 1'b0;
              st_next = TW_RACK;
              rs_next = 1'b1;
            end
            else
            begin
              oe_next = ~sh_reg[7];
              sh_next = {sh_reg[6:0], 1'b0};
              bit_next = bit_reg + 4'h1;
            end
          end
        end
        TW_RACK:
        begin
          if (rise)
          begin
            // Master NAK ends the read
            rd_next = ~sda_in;
          end
          if (fall)
          begin
            st_next = rd_reg ? TW_ACK : TW_IDLE;
          end
        end
        default:
        begin
          st_next = TW_IDLE;
        end
      endcase
    end
  end

  // Registers of the slave
  always_ff @(posedge clock_in)
  begin
    if (sys_rst_in)
    begin
      st_reg <= TW_IDLE;
      scl_reg <= 1'b1;
      sda_reg <= 1'b1;
      sh_reg <= 8'h00;
      bit_reg <= 4'h0;
      ptr_reg <= 8'h00;
      have_ptr_reg <= 1'b0;
      rd_reg <= 1'b0;
      oe_reg <= 1'b0;
      wr_reg <= 1'b0;
      wd_reg <= 8'h00;
      rs_reg <= 1'b0;
    end
    else
    begin
      st_reg <= st_next;
      scl_reg <= scl_in;
      sda_reg <= sda_in;
      sh_reg <= sh_next;
      bit_reg <= bit_next;
      ptr_reg <= ptr_next;
      have_ptr_reg <= have_ptr_next;
      rd_reg <= rd_next;
      oe_reg <= oe_next;
      wr_reg <= wr_next;
      wd_reg <= wd_next;
      rs_reg <= rs_next;
    end
  end

  // Outputs from registers; the write address is the pointer less one
  assign sda_oe_out = oe_reg;
  assign wr_addr_out = ptr_reg - 8'h01;
  assign wr_data_out = wd_reg;
  assign wr_strobe_out = wr_reg;
  assign rd_addr_out = ptr_reg;
  assign rd_strobe_out = rs_reg;
endmodule
`default_nettype wire
